// ---- src/scp_pkg.sv ----
// constants and types shared by the stepper chopper protection block
package scp_pkg;
   // ********************
   // clock and timing
   // ********************
   localparam int CLK_MHZ = 200;
   localparam int BLANK_T0_NS = 600;
   localparam int BLANK_T1_NS = 900;
   localparam int BLANK_T2_NS = 1200;
   localparam int BLANK_T3_NS = 1500;
   // least times round up to whole cycles
   localparam logic [8:0] BLANK_CYC0 = 9'((BLANK_T0_NS * CLK_MHZ + 999) / 1000);
   localparam logic [8:0] BLANK_CYC1 = 9'((BLANK_T1_NS * CLK_MHZ + 999) / 1000);
   localparam logic [8:0] BLANK_CYC2 = 9'((BLANK_T2_NS * CLK_MHZ + 999) / 1000);
   localparam logic [8:0] BLANK_CYC3 = 9'((BLANK_T3_NS * CLK_MHZ + 999) / 1000);
   localparam logic [9:0] FAST_MAX_CYC = 10'h190;
   // ********************
   // error counters and open load
   // ********************
   localparam logic [1:0] ERR_LIMIT = 2'h3;
   localparam logic [5:0] OFF_CYCLES = 6'h3f;
   localparam logic [5:0] QUIET_LIMIT = 6'h3f;
   localparam logic [3:0] OPEN_LOAD_LIMIT = 4'he;
   // ********************
   // telegram layout and reset value
   // ********************
   localparam logic [11:0] TG_RESET = 12'h000;
   localparam int TG_MDA = 11;
   localparam int TG_CA_LO = 7;
   localparam int TG_PHA = 6;
   localparam int TG_MDB = 5;
   localparam int TG_CB_LO = 1;
   localparam int TG_PHB = 0;
   // ********************
   // gate bits and chopper states
   // ********************
   localparam int GATE_HS1 = 3;
   localparam int GATE_HS2 = 2;
   localparam int GATE_LS1 = 1;
   localparam int GATE_LS2 = 0;
   localparam logic [3:0] GATES_OFF = 4'h0;
   typedef enum logic [3:0] {
      BR_OFF = 4'b0001,
      BR_ON = 4'b0010,
      BR_FAST = 4'b0100,
      BR_SLOW = 4'b1000
   } scp_br_state_t;
endpackage : scp_pkg

// ---- src/scp_bridge_if.sv ----
// carrier between the top and one bridge chopper
`timescale 1ns/10ps
`default_nettype none
interface scp_bridge_if;
   logic start;
   logic currentZero;
   logic polarity;
   logic mixed;
   logic forceOff;
   logic killCycle;
   logic tripIn;
   logic ocIn;
   logic [8:0] blankLen;
   logic [3:0] gate;
   logic blanking;
   logic switchOff;
   logic ocEvent;
   modport ctrl (output start, currentZero, polarity, mixed, forceOff, killCycle, tripIn, ocIn, blankLen,
      input gate, blanking, switchOff, ocEvent);
   modport core (input start, currentZero, polarity, mixed, forceOff, killCycle, tripIn, ocIn, blankLen,
      output gate, blanking, switchOff, ocEvent);
endinterface : scp_bridge_if
`default_nettype wire

// ---- src/scp_err_counter.sv ----
// overcurrent error counter with forced off period
`timescale 1ns/10ps
`default_nettype none
module scp_err_counter (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // events
   input wire logic tick,
   input wire logic event_i,
   input wire logic clear,
   // status
   output logic flag,
   output logic forceOff
);
   logic [1:0] errCnt_r;
   logic [5:0] quiet_r;
   logic [5:0] offCnt_r;
   logic flag_r;

   // event counted after a clear in the same cycle, so it is never lost
   always_ff @(posedge core_clk) begin
      if (rst) begin
         errCnt_r <= 2'h0;
         quiet_r <= 6'h0;
         offCnt_r <= 6'h0;
         flag_r <= 1'b0;
      end else if (event_i) begin
         quiet_r <= 6'h0;
         if (clear ? 1'b0 : (errCnt_r == scp_pkg::ERR_LIMIT - 2'h1)) begin
            errCnt_r <= scp_pkg::ERR_LIMIT;
            flag_r <= 1'b1;
            offCnt_r <= scp_pkg::OFF_CYCLES;
         end else begin
            errCnt_r <= clear ? 2'h1 : errCnt_r + 2'h1;
            if (clear) begin
               flag_r <= 1'b0;
               offCnt_r <= 6'h0;
            end
         end
      end else if (clear) begin
         errCnt_r <= 2'h0;
         flag_r <= 1'b0;
         offCnt_r <= 6'h0;
      end else if (tick) begin
         if (offCnt_r != 6'h0) begin
            offCnt_r <= offCnt_r - 6'h1;
         end
         if (quiet_r == scp_pkg::QUIET_LIMIT) begin
            errCnt_r <= 2'h0;
         end else begin
            quiet_r <= quiet_r + 6'h1;
         end
      end
   end

   assign flag = flag_r;
   assign forceOff = offCnt_r != 6'h0;
endmodule : scp_err_counter
`default_nettype wire

// ---- src/scp_bridge.sv ----
// one full bridge chopper with blanking and decay modes
`timescale 1ns/10ps
`default_nettype none
module scp_bridge (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // bridge control and status
   scp_bridge_if.core br
);
   scp_pkg::scp_br_state_t state_r, state_nxt;
   logic [8:0] blankCnt_r;
   logic [9:0] onCnt_r;
   logic [9:0] fastCnt_r;
   logic [9:0] fastLen;
   logic polarity_r;
   logic restart;
   logic ocHit;
   logic tripHit;

   assign restart = br.start | (br.polarity != polarity_r);
   assign br.blanking = blankCnt_r != 9'h0;
   assign ocHit = br.ocIn & ~br.blanking & (state_r != scp_pkg::BR_OFF);
   assign tripHit = br.tripIn & ~br.blanking & (state_r == scp_pkg::BR_ON);
   // longer on phase leaves less fast decay
   assign fastLen = (onCnt_r < scp_pkg::FAST_MAX_CYC) ? scp_pkg::FAST_MAX_CYC - onCnt_r : 10'h0;

   always_comb begin
      state_nxt = state_r;
      if (restart) begin
         state_nxt = br.forceOff ? scp_pkg::BR_OFF : (br.currentZero ? scp_pkg::BR_SLOW : scp_pkg::BR_ON);
      end else if (br.killCycle | br.forceOff | ocHit) begin
         state_nxt = scp_pkg::BR_OFF;
      end else begin
         case (state_r)
            scp_pkg::BR_ON: begin
               if (tripHit) begin
                  state_nxt = (br.mixed && fastLen != 10'h0) ? scp_pkg::BR_FAST : scp_pkg::BR_SLOW;
               end
            end
            scp_pkg::BR_FAST: begin
               if (fastCnt_r == 10'h0) begin
                  state_nxt = scp_pkg::BR_SLOW;
               end
            end
            default: state_nxt = state_r;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= scp_pkg::BR_OFF;
         polarity_r <= 1'b0;
         fastCnt_r <= 10'h0;
      end else begin
         state_r <= state_nxt;
         polarity_r <= br.polarity;
         if (state_r == scp_pkg::BR_ON && state_nxt == scp_pkg::BR_FAST) begin
            fastCnt_r <= fastLen - 10'h1;
         end else if (fastCnt_r != 10'h0) begin
            fastCnt_r <= fastCnt_r - 10'h1;
         end
      end
   end

   // blank counter restarts on every switching event
   always_ff @(posedge core_clk) begin
      if (rst) begin
         blankCnt_r <= 9'h0;
         onCnt_r <= 10'h0;
      end else begin
         if (state_nxt != state_r || restart) begin
            blankCnt_r <= br.blankLen;
         end else if (blankCnt_r != 9'h0) begin
            blankCnt_r <= blankCnt_r - 9'h1;
         end
         if (restart) begin
            onCnt_r <= 10'h0;
         end else if (state_r == scp_pkg::BR_ON && onCnt_r != 10'h3ff) begin
            onCnt_r <= onCnt_r + 10'h1;
         end
      end
   end

   always_comb begin
      br.gate = scp_pkg::GATES_OFF;
      case (state_r)
         scp_pkg::BR_ON: begin
            br.gate[polarity_r ? scp_pkg::GATE_HS2 : scp_pkg::GATE_HS1] = 1'b1;
            br.gate[polarity_r ? scp_pkg::GATE_LS1 : scp_pkg::GATE_LS2] = 1'b1;
         end
         scp_pkg::BR_FAST: br.gate[polarity_r ? scp_pkg::GATE_LS2 : scp_pkg::GATE_LS1] = 1'b1;
         scp_pkg::BR_SLOW: begin
            br.gate[scp_pkg::GATE_LS1] = 1'b1;
            br.gate[scp_pkg::GATE_LS2] = 1'b1;
         end
         default: br.gate = scp_pkg::GATES_OFF;
      endcase
   end

   assign br.switchOff = tripHit;
   assign br.ocEvent = ocHit;
endmodule : scp_bridge
`default_nettype wire

// ---- src/scp_protection_top.sv ----
// top of the stepper chopper and protection logic
`timescale 1ns/10ps
`default_nettype none
module scp_protection_top (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // pins from outside the clock domain
   input wire logic standbyDisablePin,
   input wire logic oscClkIn,
   input wire logic blankSelectLo,
   input wire logic blankSelectHi,
   input wire logic logicUndervoltage,
   input wire logic overtempDetect,
   input wire logic senseTripA,
   input wire logic senseTripB,
   input wire logic lowsideOverA,
   input wire logic lowsideOverB,
   input wire logic highsideOver,
   input wire logic [2:0] loadMeasure,
   // oscillator pin drive
   output logic oscPinOut,
   output logic oscPinOeN,
   // telegrams from the serial receiver
   input wire logic telegramValid,
   input wire logic [11:0] telegramWord,
   input wire logic standbyRequest,
   // bridge gates, high side 1, high side 2, low side 1, low side 2
   output logic [3:0] gateA,
   output logic [3:0] gateB,
   // mode outputs
   output logic standbyActive,
   output logic referencesOn,
   output logic serialHoldReset,
   // status
   output logic lowsideOvercurrentFlagA,
   output logic lowsideOvercurrentFlagB,
   output logic highsideOvercurrentFlag,
   output logic overtempFlag,
   output logic openLoadFlagA,
   output logic openLoadFlagB,
   output logic [2:0] loadIndicator
);
   // ********************
   // pin synchronisers
   // ********************
   localparam int PIN_ENN = 0;
   localparam int PIN_OSC = 1;
   localparam int PIN_BLLO = 2;
   localparam int PIN_BLHI = 3;
   localparam int PIN_UV = 4;
   localparam int PIN_OT = 5;
   localparam int PIN_TRA = 6;
   localparam int PIN_TRB = 7;
   localparam int PIN_OCA = 8;
   localparam int PIN_OCB = 9;
   localparam int PIN_OCH = 10;
   localparam int PIN_LD = 11;
   localparam int PIN_COUNT = 14;

   logic [PIN_COUNT-1:0] pinRaw;
   logic [PIN_COUNT-1:0] syncStage1_r;
   logic [PIN_COUNT-1:0] syncStage2_r;
   logic oscPrev_r;

   assign pinRaw = {loadMeasure, highsideOver, lowsideOverB, lowsideOverA, senseTripB, senseTripA,
      overtempDetect, logicUndervoltage, blankSelectHi, blankSelectLo, oscClkIn, standbyDisablePin};

   // first stage feeds only the second stage
   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : gSync
         always_ff @(posedge core_clk) begin
            if (rst) begin
               syncStage1_r[gi] <= 1'b0;
               syncStage2_r[gi] <= 1'b0;
            end else begin
               syncStage1_r[gi] <= pinRaw[gi];
               syncStage2_r[gi] <= syncStage1_r[gi];
            end
         end
      end
   endgenerate

   // ********************
   // modes
   // ********************
   logic shutdown;
   logic clearAll;
   logic [11:0] telegram_r;
   logic [3:0] currentA;
   logic [3:0] currentB;
   logic bothZero;
   logic newBothZero;
   logic standby;
   logic overtemp;
   logic powerOff;

   assign shutdown = syncStage2_r[PIN_ENN];
   assign clearAll = rst | shutdown;
   assign overtemp = syncStage2_r[PIN_OT];
   assign currentA = telegram_r[scp_pkg::TG_CA_LO +: 4];
   assign currentB = telegram_r[scp_pkg::TG_CB_LO +: 4];
   assign bothZero = currentA == 4'h0 && currentB == 4'h0;
   assign newBothZero = telegramWord[scp_pkg::TG_CA_LO +: 4] == 4'h0 && telegramWord[scp_pkg::TG_CB_LO +: 4] == 4'h0;
   assign standby = standbyRequest | syncStage2_r[PIN_UV] | bothZero;
   assign powerOff = standby | overtemp | shutdown;

   // serial side held in reset while shut down
   always_ff @(posedge core_clk) begin
      if (clearAll) begin
         telegram_r <= scp_pkg::TG_RESET;
      end else if (telegramValid) begin
         telegram_r <= telegramWord;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         standbyActive <= 1'b0;
         referencesOn <= 1'b0;
         serialHoldReset <= 1'b1;
         oscPinOut <= 1'b0;
         oscPinOeN <= 1'b1;
      end else begin
         standbyActive <= standby | shutdown;
         referencesOn <= ~shutdown;
         serialHoldReset <= shutdown;
         oscPinOut <= 1'b0;
         oscPinOeN <= ~(standby | shutdown);
      end
   end

   // ********************
   // oscillator and blank time
   // ********************
   logic oscRise;
   logic oscFall;
   logic [8:0] blankLen;

   function automatic logic [8:0] blankCycles(input logic [1:0] sel);
      logic [8:0] cyc;
      cyc = scp_pkg::BLANK_CYC0;
      if (sel == 2'h1) begin
         cyc = scp_pkg::BLANK_CYC1;
      end else if (sel == 2'h2) begin
         cyc = scp_pkg::BLANK_CYC2;
      end else if (sel == 2'h3) begin
         cyc = scp_pkg::BLANK_CYC3;
      end
      return cyc;
   endfunction : blankCycles

   always_ff @(posedge core_clk) begin
      if (rst) begin
         oscPrev_r <= 1'b0;
      end else begin
         oscPrev_r <= syncStage2_r[PIN_OSC];
      end
   end

   // edges are dropped in standby, so the chopper stands still
   assign oscRise = syncStage2_r[PIN_OSC] & ~oscPrev_r & ~standby & ~shutdown;
   assign oscFall = ~syncStage2_r[PIN_OSC] & oscPrev_r & ~standby & ~shutdown;
   assign blankLen = blankCycles({syncStage2_r[PIN_BLHI], syncStage2_r[PIN_BLLO]});

   // ********************
   // bridges
   // ********************
   scp_bridge_if brA ();
   scp_bridge_if brB ();
   logic hsHit;
   logic clrOc;
   logic offA;
   logic offB;
   logic offHs;

   // high side fault cannot be pinned on one bridge
   assign hsHit = syncStage2_r[PIN_OCH] & ~(brA.blanking | brB.blanking) & ~powerOff;
   // clear first: counters take an event arriving with the clear as count one, flag stays clear
   assign clrOc = telegramValid & newBothZero;

   assign brA.start = oscRise;
   assign brA.currentZero = currentA == 4'h0;
   assign brA.polarity = telegram_r[scp_pkg::TG_PHA];
   assign brA.mixed = telegram_r[scp_pkg::TG_MDA];
   assign brA.forceOff = offA | offHs;
   assign brA.killCycle = hsHit | powerOff;
   assign brA.tripIn = syncStage2_r[PIN_TRA];
   assign brA.ocIn = syncStage2_r[PIN_OCA];
   assign brA.blankLen = blankLen;

   assign brB.start = oscFall;
   assign brB.currentZero = currentB == 4'h0;
   assign brB.polarity = telegram_r[scp_pkg::TG_PHB];
   assign brB.mixed = telegram_r[scp_pkg::TG_MDB];
   assign brB.forceOff = offB | offHs;
   assign brB.killCycle = hsHit | powerOff;
   assign brB.tripIn = syncStage2_r[PIN_TRB];
   assign brB.ocIn = syncStage2_r[PIN_OCB];
   assign brB.blankLen = blankLen;

   scp_bridge uBridgeA (
      .core_clk(core_clk),
      .rst(clearAll),
      .br(brA)
   );

   scp_bridge uBridgeB (
      .core_clk(core_clk),
      .rst(clearAll),
      .br(brB)
   );

   // ********************
   // error counters
   // ********************
   scp_err_counter uErrA (
      .core_clk(core_clk),
      .rst(clearAll),
      .tick(oscRise),
      .event_i(brA.ocEvent),
      .clear(clrOc),
      .flag(lowsideOvercurrentFlagA),
      .forceOff(offA)
   );

   scp_err_counter uErrB (
      .core_clk(core_clk),
      .rst(clearAll),
      .tick(oscFall),
      .event_i(brB.ocEvent),
      .clear(clrOc),
      .flag(lowsideOvercurrentFlagB),
      .forceOff(offB)
   );

   scp_err_counter uErrHs (
      .core_clk(core_clk),
      .rst(clearAll),
      .tick(oscRise),
      .event_i(hsHit),
      .clear(clrOc),
      .flag(highsideOvercurrentFlag),
      .forceOff(offHs)
   );

   // ********************
   // gate outputs
   // ********************
   always_ff @(posedge core_clk) begin
      if (clearAll) begin
         gateA <= scp_pkg::GATES_OFF;
         gateB <= scp_pkg::GATES_OFF;
      end else if (powerOff) begin
         gateA <= scp_pkg::GATES_OFF;
         gateB <= scp_pkg::GATES_OFF;
      end else begin
         gateA <= brA.gate;
         gateB <= brB.gate;
      end
   end

   // ********************
   // open load
   // ********************
   logic [3:0] olCnt_r [2];
   logic [1:0] olTick;
   logic [1:0] olSwitch;
   logic [1:0] olZero;
   logic faultAny;

   assign olTick = {oscFall, oscRise};
   assign olSwitch = {brB.switchOff, brA.switchOff};
   assign olZero = {brB.currentZero, brA.currentZero};
   assign faultAny = lowsideOvercurrentFlagA | lowsideOvercurrentFlagB | highsideOvercurrentFlag
      | syncStage2_r[PIN_UV] | overtemp;

   always_ff @(posedge core_clk) begin
      if (clearAll) begin
         for (int i = 0; i < 2; i++) begin
            olCnt_r[i] <= 4'h0;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (olSwitch[i] || olZero[i]) begin
               olCnt_r[i] <= 4'h0;
            end else if (olTick[i] && olCnt_r[i] <= scp_pkg::OPEN_LOAD_LIMIT) begin
               olCnt_r[i] <= olCnt_r[i] + 4'h1;
            end
         end
      end
   end

   // zero current means chopper off, so the flag reads inactive
   always_ff @(posedge core_clk) begin
      if (clearAll) begin
         openLoadFlagA <= 1'b0;
         openLoadFlagB <= 1'b0;
      end else begin
         openLoadFlagA <= ~olZero[0] & (olCnt_r[0] > scp_pkg::OPEN_LOAD_LIMIT | faultAny);
         openLoadFlagB <= ~olZero[1] & (olCnt_r[1] > scp_pkg::OPEN_LOAD_LIMIT | faultAny);
      end
   end

   // ********************
   // load indicator and overtemperature
   // ********************
   logic fullstep;

   // a polarity toggle on either coil marks one fullstep
   assign fullstep = telegramValid & ((telegramWord[scp_pkg::TG_PHA] != telegram_r[scp_pkg::TG_PHA])
      | (telegramWord[scp_pkg::TG_PHB] != telegram_r[scp_pkg::TG_PHB]));

   // value only meaningful with mixed decay off; controller times its read
   always_ff @(posedge core_clk) begin
      if (clearAll) begin
         loadIndicator <= 3'h0;
      end else if (fullstep && !telegram_r[scp_pkg::TG_MDA] && !telegram_r[scp_pkg::TG_MDB]) begin
         loadIndicator <= syncStage2_r[PIN_LD +: 3];
      end
   end

   always_ff @(posedge core_clk) begin
      if (clearAll) begin
         overtempFlag <= 1'b0;
      end else begin
         overtempFlag <= overtemp;
      end
   end
endmodule : scp_protection_top
`default_nettype wire

// ---- verif/scp_protection_checker.sv ----
// assertion checker for the chopper protection top
`timescale 1ns/10ps
`default_nettype none
module scp_protection_checker (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // pins
   input wire logic standbyDisablePin,
   input wire logic logicUndervoltage,
   input wire logic overtempDetect,
   input wire logic telegramValid,
   input wire logic [11:0] telegramWord,
   // outputs
   input wire logic oscPinOut,
   input wire logic oscPinOeN,
   input wire logic [3:0] gateA,
   input wire logic [3:0] gateB,
   input wire logic standbyActive,
   input wire logic referencesOn,
   input wire logic serialHoldReset,
   input wire logic lowsideOvercurrentFlagA,
   input wire logic lowsideOvercurrentFlagB,
   input wire logic highsideOvercurrentFlag,
   input wire logic overtempFlag
);
   // ****
   // properties
   // ****
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire logic gatesOff = gateA == scp_pkg::GATES_OFF && gateB == scp_pkg::GATES_OFF;
   wire logic anyFlag = lowsideOvercurrentFlagA | lowsideOvercurrentFlagB | highsideOvercurrentFlag;
   wire logic zeroCmd = telegramValid && telegramWord[10:7] == 4'h0 && telegramWord[4:1] == 4'h0;
   a_standby_gates_off: assert property (standbyActive [*2] |-> gatesOff)
      else $error("gates on in standby");
   a_osc_pin_low: assert property (oscPinOut == 1'b0)
      else $error("osc pin high");
   a_osc_held_low: assert property (standbyActive [*3] |-> !oscPinOeN)
      else $error("osc pin released");
   a_uv_standby: assert property (logicUndervoltage [*5] |-> standbyActive)
      else $error("no standby on undervoltage");
   a_shutdown_hold: assert property (standbyDisablePin [*5] |->
      serialHoldReset && !referencesOn && gatesOff && !anyFlag && !overtempFlag)
      else $error("shutdown state wrong");
   a_zero_clear: assert property (zeroCmd |-> ##2 (standbyActive && !anyFlag))
      else $error("zero telegram ignored");
   a_ot_flag: assert property ((overtempDetect && !standbyDisablePin) [*5] |-> overtempFlag)
      else $error("overtemp not flagged");
   a_oc_hold_off: assert property ($rose(lowsideOvercurrentFlagA) |-> ##1 (gateA == 4'h0) [*8])
      else $error("bridge on after flag");
   a_no_shoot: assert property (!(gateA[3] && gateA[1]) && !(gateA[2] && gateA[0])
      && !(gateB[3] && gateB[1]) && !(gateB[2] && gateB[0]))
      else $error("shoot through");
   c_oc_flag: cover property ($rose(lowsideOvercurrentFlagA));
   c_hs_flag: cover property ($rose(highsideOvercurrentFlag));
   c_wake: cover property ($fell(standbyActive));
endmodule : scp_protection_checker
bind scp_protection_top scp_protection_checker u_scp_protection_checker (.core_clk, .rst, .standbyDisablePin,
   .logicUndervoltage, .overtempDetect, .telegramValid, .telegramWord, .oscPinOut, .oscPinOeN, .gateA, .gateB,
   .standbyActive, .referencesOn, .serialHoldReset, .lowsideOvercurrentFlagA, .lowsideOvercurrentFlagB,
   .highsideOvercurrentFlag, .overtempFlag);
`default_nettype wire

// ---- verif/scp_motion_ctrl_model.sv ----
// motion controller model sending telegrams
`timescale 1ns/10ps
`default_nettype none
module scp_motion_ctrl_model (
   // clock
   input wire logic core_clk,
   // telegram side
   output logic telegramValid = 1'b0,
   output logic [11:0] telegramWord = 12'h000,
   output logic standbyRequest = 1'b0,
   // readback
   input wire logic [2:0] loadIndicator
);
   // ****
   // telegrams and load readout
   // ****
   // one chopper period plus 8 us in core cycles
   localparam int LOAD_WAIT = 1632;
   localparam logic [2:0] STALL_LEVEL = 3'h2;
   int cyc = 0;
   int lastToggle = 0;
   always @(posedge core_clk) cyc <= cyc + 1;
   task automatic send(input logic [11:0] w);
      @(posedge core_clk);
      if (w[6] != telegramWord[6] || w[0] != telegramWord[0]) lastToggle = cyc;
      telegramValid <= 1'b1;
      telegramWord <= w;
      @(posedge core_clk);
      telegramValid <= 1'b0;
   endtask : send
   task automatic hold(input logic s);
      @(posedge core_clk);
      standbyRequest <= s;
   endtask : hold
   // an early read still shows the last fullstep
   task automatic readLoad(output logic [2:0] v, output logic stall);
      while (cyc - lastToggle < LOAD_WAIT) @(posedge core_clk);
      v = loadIndicator;
      stall = loadIndicator <= STALL_LEVEL;
   endtask : readLoad
endmodule : scp_motion_ctrl_model
`default_nettype wire

// ---- verif/scp_protection_top_tb.sv ----
// self-checking bench for the chopper protection top
`timescale 1ns/10ps
`default_nettype none
module scp_protection_top_tb;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic dis, uv, ot, tripA;
   logic osc = 1'b0;
   logic oscRun = 1'b0;
   logic [1:0] bsel;
   logic [2:0] oc;
   logic [2:0] ldIn;
   logic [2:0] ldv;
   logic stall;
   wire logic valid, stbyReq, oscOut, oscOeN, stby, refOn, serRst, flA, flB, flH, flT, open_load_flag_a, open_load_flag_b;
   wire logic [11:0] word;
   wire logic [3:0] gA, gB;
   wire logic [2:0] load;
   int failCount = 0;
   int nCompared = 0;
   always #2.5 core_clk = ~core_clk;
   // oscillator edges land on falling core edges, between rising ones; stops when asked
   always #80 if (oscRun) osc = ~osc;
   scp_protection_top u_scp_protection_top (.core_clk, .rst, .standbyDisablePin(dis), .oscClkIn(osc),
      .blankSelectLo(bsel[0]), .blankSelectHi(bsel[1]), .logicUndervoltage(uv), .overtempDetect(ot),
      .senseTripA(tripA), .senseTripB(tripA), .lowsideOverA(oc[0]), .lowsideOverB(oc[1]), .highsideOver(oc[2]),
      .loadMeasure(ldIn), .oscPinOut(oscOut), .oscPinOeN(oscOeN), .telegramValid(valid), .telegramWord(word),
      .standbyRequest(stbyReq), .gateA(gA), .gateB(gB), .standbyActive(stby), .referencesOn(refOn),
      .serialHoldReset(serRst), .lowsideOvercurrentFlagA(flA), .lowsideOvercurrentFlagB(flB),
      .highsideOvercurrentFlag(flH), .overtempFlag(flT), .openLoadFlagA(open_load_flag_a), .openLoadFlagB(open_load_flag_b),
      .loadIndicator(load));
   scp_motion_ctrl_model u_scp_motion_ctrl_model (.core_clk, .telegramValid(valid), .telegramWord(word),
      .standbyRequest(stbyReq), .loadIndicator(load));
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      nCompared++;
      if (seen !== exp) begin
         failCount++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   task automatic rise();
      oscRun = 1'b1;
      @(posedge osc);
      oscRun = 1'b0;
   endtask : rise
   task automatic run(input int n);
      repeat (n) rise();
   endtask : run
   task automatic hit(input logic [2:0] p, input logic [3:0] expB);
      rise();
      cyc(10);
      oc <= p;
      cyc(8);
      oc <= 3'h0;
      check("blanked", gA, 4'h9);
      cyc(150);
      oc <= p;
      cyc(8);
      oc <= 3'h0;
      check("cut", {gA, gB}, {4'h0, expB});
   endtask : hit
   task automatic reportAndStop();
      $display("compared %0d mismatches %0d", nCompared, failCount);
      if (failCount == 0 && nCompared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : reportAndStop
   initial begin
      cyc(40000);
      failCount++;
      $display("watchdog expired");
      reportAndStop();
   end
   initial begin
      {dis, uv, ot, tripA, bsel, oc, ldIn} <= 12'h000;
      cyc(3);
      rst <= 1'b0;
      cyc(4);
      check("idle", {stby, oscOut, oscOeN}, 3'h4);
      check("refs", {refOn, serRst, gA, gB}, 10'h200);
      $display("test reset done");
      u_scp_motion_ctrl_model.send(12'h79e);
      run(20);
      ldIn <= 3'h5;
      cyc(150);
      check("running", {stby, oscOeN, open_load_flag_b, open_load_flag_a, gA}, 8'h79);
      tripA <= 1'b1;
      cyc(8);
      check("slow", gA, 4'h3);
      u_scp_motion_ctrl_model.send(12'h7de);
      cyc(4);
      check("restart", gA, 4'h6);
      ldIn <= 3'h2;
      u_scp_motion_ctrl_model.readLoad(ldv, stall);
      check("load", {stall, ldv}, 4'h5);
      u_scp_motion_ctrl_model.send(12'hf9e);
      cyc(150);
      check("fast", gA, 4'h2);
      u_scp_motion_ctrl_model.readLoad(ldv, stall);
      check("stall", {stall, ldv, gA}, 8'ha3);
      tripA <= 1'b0;
      $display("test chopper done");
      u_scp_motion_ctrl_model.send(12'h79e);
      repeat (3) hit(3'h3, 4'h0);
      cyc(2);
      check("oc flags", {flH, flB, flA}, 3'h3);
      run(10);
      cyc(150);
      check("forced off", gA, 4'h0);
      u_scp_motion_ctrl_model.send(12'h000);
      cyc(2);
      check("cleared", {flB, flA}, 2'h0);
      u_scp_motion_ctrl_model.send(12'h79e);
      rise();
      cyc(150);
      check("early end", gA, 4'h9);
      run(66);
      repeat (2) hit(3'h1, 4'h9);
      run(66);
      repeat (2) hit(3'h1, 4'h9);
      cyc(2);
      check("quiet", flA, 1'b0);
      for (int k = 0; k < 4; k++) begin
         bsel <= 2'(k);
         cyc(3);
         rise();
         cyc(98 + 60 * k);
         oc <= 3'h1;
         cyc(8);
         oc <= 3'h0;
         check("blank len", gA, 4'h9);
      end
      bsel <= 2'h0;
      repeat (3) hit(3'h4, 4'h0);
      cyc(2);
      check("hs flag", {flH, flB, flA}, 3'h4);
      $display("test overcurrent done");
      u_scp_motion_ctrl_model.send(12'h000);
      u_scp_motion_ctrl_model.send(12'h79e);
      ot <= 1'b1;
      cyc(8);
      check("hot", {flT, gA, gB}, 9'h100);
      ot <= 1'b0;
      rise();
      cyc(150);
      check("cooled", {flT, gA}, 5'h09);
      uv <= 1'b1;
      cyc(8);
      check("uv", {stby, oscOeN, gA, gB}, 10'h200);
      uv <= 1'b0;
      u_scp_motion_ctrl_model.hold(1'b1);
      cyc(8);
      check("user standby", {stby, oscOeN, gA, gB}, 10'h200);
      u_scp_motion_ctrl_model.hold(1'b0);
      rise();
      cyc(150);
      check("resumed", {stby, gA}, 5'h09);
      dis <= 1'b1;
      cyc(4);
      u_scp_motion_ctrl_model.send(12'h79e);
      cyc(8);
      check("shutdown", {serRst, refOn, open_load_flag_a, gA, gB}, 11'h400);
      dis <= 1'b0;
      cyc(8);
      check("refused", {stby, serRst, refOn}, 3'h5);
      $display("test protection done");
      reportAndStop();
   end
endmodule : scp_protection_top_tb
`default_nettype wire
